// ==== pkg/ebh_defines.svh ====
// constants for the external bus hold handshake
`ifndef EBH_DEFINES_SVH
`define EBH_DEFINES_SVH
`define EBH_ADDR_W 20
`define EBH_DATA_W 16
`define EBH_STRB_W 4
`define EBH_STRB_IDLE 4'hf
`define EBH_SYNC_STAGES 2
`endif

// ==== pkg/ebh_pkg.sv ====
// types for the external bus hold handshake
package ebh_pkg;
	typedef enum logic [1:0] {
		EBH_OWN = 2'b00,
		EBH_DRAIN = 2'b01,
		EBH_GRANTED = 2'b10
	} ebh_state_type;
endpackage : ebh_pkg

// ==== logic/ebh_hold_ctrl.sv ====
// external bus hold handshake and shared trip pin resolution
`include "ebh_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ebh_hold_ctrl (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ext_bus_hold_request_n,
	input wire logic ext_if_config_second_hold_dis,
	input wire logic port_a_direction_reg_bit,
	input wire logic trip_four_enable,
	input wire logic trip_three_enable,
	input wire logic ext_bus_hold_grant_n_in,
	input wire logic access_busy,
	input wire logic access_pending,
	input wire logic [`EBH_ADDR_W-1:0] if_addr,
	input wire logic [`EBH_DATA_W-1:0] if_wdata,
	input wire logic if_data_drive,
	input wire logic [`EBH_STRB_W-1:0] if_strobe_n,
	output logic ext_bus_hold_grant_n,
	output logic ext_bus_hold_grant_n_oe,
	output logic accept_new_access,
	output logic [`EBH_ADDR_W-1:0] addr_out,
	output logic addr_oe,
	output logic [`EBH_DATA_W-1:0] data_out,
	output logic data_oe,
	output logic [`EBH_STRB_W-1:0] strobe_n_out,
	output logic strobe_oe,
	output logic trip_input_three,
	output logic trip_input_four
);
	import ebh_pkg::*;

	ebh_state_type state_reg;
	ebh_state_type state_next;
	logic req_sync_reg;
	logic t4_sync_reg;
	logic hold_req;
	logic float_next;

	// pins come from outside the clock domain; idle level is high
	ebh_sync #(
		.RST_VAL(1'b1)
	) u_req_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pin_in(ext_bus_hold_request_n),
		.level_out(req_sync_reg)
	);
	// shared ack pin read back; only matters while it is an input
	ebh_sync #(
		.RST_VAL(1'b1)
	) u_t4_sync (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.pin_in(ext_bus_hold_grant_n_in),
		.level_out(t4_sync_reg)
	);

	// disable bit masks the shared trip pin as a hold source
	always_comb begin
		hold_req = !req_sync_reg
			&& !ext_if_config_second_hold_dis;
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			EBH_OWN: begin
				if (hold_req) begin
					state_next = EBH_DRAIN;
				end
			end
			EBH_DRAIN: begin
				if (!hold_req) begin
					state_next = EBH_OWN;
				end else if (!access_busy && !access_pending) begin
					state_next = EBH_GRANTED;
				end
			end
			EBH_GRANTED: begin
				// a set disable bit also ends a grant
				if (!hold_req) begin
					state_next = EBH_OWN;
				end
			end
			default: begin
				state_next = EBH_OWN;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= EBH_OWN;
		end else begin
			state_reg <= state_next;
		end
	end

	// stop queueing once a hold is requested so the drain can finish
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			accept_new_access <= 1'b1;
		end else begin
			accept_new_access <= (state_next == EBH_OWN);
		end
	end

	// float from the grant onward; hold disable wins over a stuck grant
	always_comb begin
		float_next = (state_next == EBH_GRANTED);
	end

	// enables and ack share one edge so no pin overlap can occur
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			addr_out <= '0;
			addr_oe <= 1'b0;
		end else begin
			addr_out <= if_addr;
			addr_oe <= !float_next;
		end
	end

	// data floats while granted, and otherwise unless a write needs it
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			data_out <= '0;
			data_oe <= 1'b0;
		end else begin
			data_out <= if_wdata;
			data_oe <= !float_next && if_data_drive;
		end
	end

	// strobes idle high so a released pin reads inactive
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			strobe_n_out <= `EBH_STRB_IDLE;
			strobe_oe <= 1'b0;
		end else begin
			strobe_n_out <= if_strobe_n;
			strobe_oe <= !float_next;
		end
	end

	// acknowledge level, registered to keep the pin glitch free
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ext_bus_hold_grant_n <= 1'b1;
		end else begin
			ext_bus_hold_grant_n <= !float_next;
		end
	end

	// acknowledge: pin is ours only when direction selects output
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ext_bus_hold_grant_n_oe <= 1'b0;
		end else begin
			ext_bus_hold_grant_n_oe <= port_a_direction_reg_bit;
		end
	end

	// trip levels to pwm, off unless enabled; high means inactive
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			trip_input_three <= 1'b1;
		end else begin
			trip_input_three <= req_sync_reg || !trip_three_enable;
		end
	end

	// own ack would trip the pwm, so output mode forces inactive
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			trip_input_four <= 1'b1;
		end else begin
			trip_input_four <= t4_sync_reg || !trip_four_enable
				|| port_a_direction_reg_bit;
		end
	end
endmodule : ebh_hold_ctrl

// two-flop synchroniser for a level from outside the clock domain
module ebh_sync #(
	parameter logic RST_VAL = 1'b1
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic pin_in,
	output logic level_out
);
	logic meta_reg;

	// first flop may go metastable; only the second is read outside
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta_reg <= RST_VAL;
		end else begin
			meta_reg <= pin_in;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			level_out <= RST_VAL;
		end else begin
			level_out <= meta_reg;
		end
	end
endmodule : ebh_sync
`default_nettype wire

// ==== testbench/ebh_chk.sv ====
// assertions for the hold handshake
`timescale 1ns/1ps
`default_nettype none
module ebh_chk (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic ext_bus_hold_request_n,
	input wire logic ext_if_config_second_hold_dis,
	input wire logic port_a_direction_reg_bit,
	input wire logic access_busy,
	input wire logic access_pending,
	input wire logic ext_bus_hold_grant_n,
	input wire logic ext_bus_hold_grant_n_oe,
	input wire logic accept_new_access,
	input wire logic addr_oe,
	input wire logic data_oe,
	input wire logic strobe_oe,
	input wire logic trip_input_four
);
	wire logic g = ext_bus_hold_grant_n;
	wire logic dir = port_a_direction_reg_bit;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_req_idle;
		!ext_bus_hold_request_n && !ext_if_config_second_hold_dis &&
		!access_busy && !access_pending;
	endsequence
	sequence s_held;
		!g [*2] ##1 g && addr_oe;
	endsequence
	a_grant_idle: assert property (
		s_req_idle [*5] |=> !g) else $error("grant late");
	a_float_grant: assert property (
		!g |-> !addr_oe && !data_oe && !strobe_oe) else $error("bus driven");
	a_grant_quiet: assert property (
		$fell(g) |-> !$past(access_busy) && !$past(access_pending))
		else $error("grant mid access");
	a_drain_stall: assert property (
		!g |-> !accept_new_access) else $error("access let in");
	a_release_time: assert property (
		$rose(ext_bus_hold_request_n) && !g |=> s_held) else $error("release");
	a_hold_off: assert property (
		ext_if_config_second_hold_dis [*2] |=> g && addr_oe)
		else $error("hold not off");
	a_ack_dir: assert property (
		$changed(dir) |=> ext_bus_hold_grant_n_oe == $past(dir))
		else $error("ack enable");
	a_trip_dir: assert property (
		dir [*3] |-> trip_input_four) else $error("trip four");
endmodule : ebh_chk
bind ebh_hold_ctrl ebh_chk u_chk (.*);
`default_nettype wire

// ==== testbench/ebh_master.sv ====
// outside bus master model
`timescale 1ns/1ps
`default_nettype none
module ebh_master (
	input wire logic sys_clk,
	input wire logic want,
	input wire logic ack_pin_n,
	output logic req_n,
	output logic owns
);
	// request held for as long as the bus is wanted
	always_ff @(posedge sys_clk) req_n <= !want;
	assign owns = !ack_pin_n;
endmodule : ebh_master
`default_nettype wire

// ==== testbench/ext_bus_hold_handshake_tb_top.sv ====
// bench for the hold handshake
`timescale 1ns/1ps
`default_nettype none
`include "ebh_defines.svh"
module ext_bus_hold_handshake_tb_top;
	logic sys_clk = 0, nrst = 0, want = 0, trip_pin_level = 1, owns;
	logic ext_if_config_second_hold_dis = 0, port_a_direction_reg_bit = 0;
	logic trip_four_enable = 0, trip_three_enable = 0, if_data_drive = 1;
	logic access_busy = 0, access_pending = 0, ext_bus_hold_request_n;
	logic [`EBH_ADDR_W-1:0] if_addr = 20'h5a5a5, addr_out;
	logic [`EBH_DATA_W-1:0] if_wdata = 16'hc3c3, data_out;
	logic [`EBH_STRB_W-1:0] if_strobe_n = 4'h6, strobe_n_out;
	logic ext_bus_hold_grant_n, ext_bus_hold_grant_n_oe, accept_new_access;
	logic addr_oe, data_oe, strobe_oe, trip_input_three, trip_input_four;
	int n_mismatch = 0, tests_run = 0;
	wire logic ext_bus_hold_grant_n_in = ext_bus_hold_grant_n_oe ?
		ext_bus_hold_grant_n : trip_pin_level;
	ebh_hold_ctrl u_dut (.*);
	ebh_master u_master (.sys_clk, .want, .ack_pin_n(ext_bus_hold_grant_n_in),
		.req_n(ext_bus_hold_request_n), .owns);
	task cy(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : cy
	task chk(input logic s, input logic e);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: output off", $time);
		end
	endtask : chk
	task wrap_up;
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : wrap_up
	task t_grant;
		@(posedge sys_clk) want <= 1;
		port_a_direction_reg_bit <= 1;
		access_busy <= 1;
		access_pending <= 1;
		cy(8);
		chk(ext_bus_hold_grant_n && addr_oe && !accept_new_access, 1'b1);
		@(posedge sys_clk) access_busy <= 0;
		cy(4);
		chk(ext_bus_hold_grant_n, 1'b1);
		@(posedge sys_clk) access_pending <= 0;
		for (int i = 0; i < 9 && ext_bus_hold_grant_n !== 1'b0; i++) cy(0);
		chk(owns && !addr_oe && !data_oe && !strobe_oe, 1'b1);
		@(posedge sys_clk) want <= 0;
		cy(5);
		chk(ext_bus_hold_grant_n && addr_oe && addr_out === if_addr, 1'b1);
		chk(data_out === if_wdata && strobe_n_out === if_strobe_n
			&& data_oe && strobe_oe, 1'b1);
	endtask : t_grant
	task t_dis;
		@(posedge sys_clk) ext_if_config_second_hold_dis <= 1;
		want <= 1;
		if_data_drive <= 0;
		cy(8);
		chk(ext_bus_hold_grant_n && addr_oe && accept_new_access
			&& !data_oe, 1'b1);
		@(posedge sys_clk) want <= 0;
		if_data_drive <= 1;
		cy(4);
		@(posedge sys_clk) ext_if_config_second_hold_dis <= 0;
	endtask : t_dis
	task t_trip;
		@(posedge sys_clk) port_a_direction_reg_bit <= 0;
		want <= 1;
		trip_pin_level <= 0;
		cy(6);
		chk(trip_input_three && trip_input_four && !addr_oe, 1'b1);
		@(posedge sys_clk) trip_three_enable <= 1;
		trip_four_enable <= 1;
		cy(6);
		chk(trip_input_three || trip_input_four, 1'b0);
		@(posedge sys_clk) port_a_direction_reg_bit <= 1;
		cy(4);
		chk(trip_input_four && !ext_bus_hold_grant_n_in, 1'b1);
		@(posedge sys_clk) ext_if_config_second_hold_dis <= 1;
		cy(2);
		chk(ext_bus_hold_grant_n && addr_oe, 1'b1);
	endtask : t_trip
	initial forever #20 sys_clk = ~sys_clk;
	initial begin
		#20000;
		n_mismatch++;
		wrap_up;
	end
	initial begin
		cy(6);
		@(posedge sys_clk) nrst <= 1;
		t_grant;
		t_dis;
		t_trip;
		wrap_up;
	end
endmodule : ext_bus_hold_handshake_tb_top
`default_nettype wire
